// [inc/aebm_consts.svh]
/*
 external bus master constants: address and data widths, clock period, size codes, address space codes,
 acknowledge patterns, bus monitor limit.
 assumes inclusion by bare name; definitions only.
*/
`ifndef AEBM_CONSTS_SVH
`define AEBM_CONSTS_SVH
`define AEBM_ADDR_W        24
`define AEBM_DATA_W        16
`define AEBM_SIZE_BYTE     2'h1
`define AEBM_SIZE_WORD     2'h2
`define AEBM_SIZE_THREE    2'h3
`define AEBM_SIZE_LONG     2'h0
`define AEBM_SPACE_CPU     3'h7
`define AEBM_ACK_WAIT      2'h3
`define AEBM_ACK_PORT8     2'h2
`define AEBM_ACK_PORT16    2'h1
`define AEBM_MON_NS        1280
`define AEBM_CLK_NS        20
`define AEBM_MON_CYC       (`AEBM_MON_NS / `AEBM_CLK_NS)
`endif

// [inc/aebm_pkg.sv]
/*
 types shared by the external bus master and its helpers.
 assumes aebm_consts.svh for widths.
*/
`include "aebm_consts.svh"
package aebm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SETUP = 3'h1,
      ST_ADDR  = 3'h3,
      ST_DATA  = 3'h2,
      ST_WAIT  = 3'h6,
      ST_END   = 3'h7
   } aebm_state_t;

   typedef struct packed {
      logic [`AEBM_ADDR_W-1:0] addr;
      logic [1:0]              size;
      logic [2:0]              space;
      logic                    read;
   } aebm_ctl_t;

   typedef struct packed {
      logic                    valid;
      logic [`AEBM_ADDR_W-1:0] addr;
      logic [1:0]              size;
      logic [2:0]              space;
      logic                    read;
      logic                    iack;
      logic [31:0]             wdata;
   } aebm_req_t;

   typedef struct packed {
      logic        done;
      logic        fault;
      logic        autovec;
      logic [31:0] rdata;
   } aebm_rsp_t;
endpackage : aebm_pkg

// [core/aebm_sync.sv]
/*
 two-flop synchroniser for pin inputs, one per bit.
 assumes inputs asynchronous to i_clk_sys; output reset to rst_val.
*/
`timescale 1ns/100ps
module aebm_sync #(
   parameter int          W       = 1,
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   // clock
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   input  wire logic         i_ce,
   // data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } aebm_sync_st_t;
   aebm_sync_st_t st_r;
   aebm_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = i_d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_r.s1 <= W'(RST_VAL);
         st_r.s2 <= W'(RST_VAL);
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign o_q = st_r.s2;
endmodule : aebm_sync

// [core/aebm_lane.sv]
/*
 byte lane router: picks write lanes and merges read bytes by bytes already moved, address bit 0
 and port width. assumes byte offsets count from the most significant byte.
*/
`timescale 1ns/100ps
module aebm_lane (
   // current piece
   input  wire logic [31:0] i_wdata,
   input  wire logic [1:0]  i_done_bytes,
   input  wire logic        i_a0,
   input  wire logic        i_port8,
   // write lanes
   output logic      [15:0] o_wbus,
   // read merge
   input  wire logic [15:0] i_rbus,
   input  wire logic [31:0] i_racc,
   output logic      [31:0] o_racc,
   output logic      [1:0]  o_moved
);
   logic [7:0] b0;
   logic [7:0] b1;
   logic [4:0] sh;

   always_comb begin
      sh     = {i_done_bytes, 3'h0};
      b0     = 8'(i_wdata >> (5'h18 - sh));
      b1     = (i_done_bytes == 2'h3) ? b0 : 8'(i_wdata >> (5'h10 - sh));
      // full 16 lines always driven; odd byte mirrored on both halves
      o_wbus = i_a0 ? {b0, b0} : {b0, b1};
      o_racc = i_racc;
      if (i_port8 || i_a0) begin
         o_moved = 2'h1;
         o_racc[5'h1F - sh -: 8] = (i_port8 || !i_a0) ? i_rbus[15:8] : i_rbus[7:0];
      end else begin
         o_moved = 2'h2;
         o_racc[5'h1F - sh -: 8] = i_rbus[15:8];
         if (i_done_bytes != 2'h3) begin
            o_racc[5'h17 - sh -: 8] = i_rbus[7:0];
         end
      end
   end
endmodule : aebm_lane

// [core/aebm_master.sv]
/*
 asynchronous external bus master with dynamic 8/16-bit sizing.
 assumes: request from same-clock logic, held until o_rsp.done; pins are synchronised here.
 half-clock points are modelled as whole i_clk_sys phases (this clock is the half rate).
*/
// What this block does
// [R1] drive address, size, space, direction at start
// [R2] size lines give bytes still to move
// [R3] hold controls stable while address strobe low
// [R4] direction changes only when direction reverses
// [R5] space code picks one of eight spaces
// [R6] space seven only for control cycles
// [R7] address is most significant byte of piece
// [R8] address strobe one phase after start
// [R9] capture read data at cycle end
// [R10] writes drive all sixteen data lines
// [R11] write data one phase after strobe
// [R12] read data strobe with address strobe
// [R13] write data strobe one cycle later
// [R14] slave acknowledges to end the cycle
// [R15] acknowledge gives port width, plans next pieces
// [R16] bus error ends cycle as faulted
// [R17] internal monitor raises fault on silence
// [R18] fault with halt ends with exception
// [R19] autovector ends interrupt acknowledge cycle
// [R20] autovector ignored outside interrupt acknowledge
// [R21] split operand into cycles for narrow port
// [R22] slave response sets cycle length
// [R23] acknowledge pair decode, reserved means wait
// [R24] eight-bit port uses upper lines only
`timescale 1ns/100ps
`include "aebm_consts.svh"
module aebm_master (
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset,
   input  wire logic                    i_ce,
   // internal request
   input  wire aebm_pkg::aebm_req_t     i_req,
   output aebm_pkg::aebm_rsp_t          o_rsp,
   output logic                         o_busy,
   output logic                         o_halt_fault,
   // bus outputs
   output aebm_pkg::aebm_ctl_t          o_ctl,
   output logic                         o_addr_valid_strobe_n,
   output logic                         o_data_valid_strobe_n,
   // data pins
   input  wire logic [`AEBM_DATA_W-1:0] i_data,
   output logic      [`AEBM_DATA_W-1:0] o_data,
   output logic                         o_data_oe,
   // terminations (pins)
   input  wire logic                    i_xfer_ack_hi_n,
   input  wire logic                    i_xfer_ack_lo_n,
   input  wire logic                    i_bus_fault_term_n,
   input  wire logic                    i_halt_n,
   input  wire logic                    i_auto_vector_request_n
);
   localparam logic [7:0] MON_CYC = 8'(`AEBM_MON_CYC);

   typedef struct packed {
      aebm_pkg::aebm_state_t st;
      aebm_pkg::aebm_ctl_t   ctl;
      logic                  as_n;
      logic                  ds_n;
      logic                  oe;
      logic [15:0]           dout;
      logic [1:0]            done_bytes;
      logic [1:0]            total;
      logic [31:0]           racc;
      logic [7:0]            mon;
      logic                  fault;
      logic                  halt;
      logic                  autovec;
      aebm_pkg::aebm_rsp_t   rsp;
   } aebm_st_t;

   aebm_st_t st_r;
   aebm_st_t st_nxt;

   logic [4:0]  sync_in;
   logic [15:0] din_s;
   logic        ack_hi_n;
   logic        ack_lo_n;
   logic        fault_n;
   logic        halt_n;
   logic        auto_vector_request_n;
   logic [15:0] wbus;
   logic [31:0] racc_m;
   logic [1:0]  moved;
   logic [1:0]  remain;
   logic        port8;
   logic        term_ack;

   ////////////////////////////////////////////////////////////////////////////////////
   aebm_sync #(.W(21), .RST_VAL(16'hFFFF)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_ce      (i_ce),
      .i_d       ({i_data, i_xfer_ack_hi_n, i_xfer_ack_lo_n, i_bus_fault_term_n,
                   i_halt_n, i_auto_vector_request_n}),
      .o_q       ({din_s, sync_in[4:0]})
   );
   assign ack_hi_n = sync_in[4];
   assign ack_lo_n = sync_in[3];
   assign fault_n  = sync_in[2];
   assign halt_n   = sync_in[1];
   assign auto_vector_request_n   = sync_in[0];

   // [R23] wait and reserved patterns do not end the cycle
   assign term_ack = ({ack_hi_n, ack_lo_n} == `AEBM_ACK_PORT8) ||
                     ({ack_hi_n, ack_lo_n} == `AEBM_ACK_PORT16);
   assign port8    = ({ack_hi_n, ack_lo_n} == `AEBM_ACK_PORT8); // [R15] [R24]

   aebm_lane u_lane (
      .i_wdata      (i_req.wdata),
      .i_done_bytes (st_r.done_bytes),
      .i_a0         (st_r.ctl.addr[0]),
      .i_port8      (port8),
      .o_wbus       (wbus),
      .i_rbus       (din_s),
      .i_racc       (st_r.racc),
      .o_racc       (racc_m),
      .o_moved      (moved)
   );

   // [R2] bytes left, encoded so long word wraps to zero
   assign remain = 2'(st_r.total - st_r.done_bytes);

   ////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt          = st_r;
      st_nxt.rsp.done = 1'b0;
      case (st_r.st)
         aebm_pkg::ST_IDLE: begin
            if (i_req.valid) begin
               st_nxt.ctl.addr   = i_req.addr;
               st_nxt.ctl.size   = i_req.size; // [R2]
               // [R6] control space only for interrupt acknowledge
               if (i_req.iack) begin
                  st_nxt.ctl.space = `AEBM_SPACE_CPU;
               end else if (i_req.space == `AEBM_SPACE_CPU) begin
                  st_nxt.ctl.space = 3'h5;
               end else begin
                  st_nxt.ctl.space = i_req.space; // [R5]
               end
               st_nxt.ctl.read   = i_req.read | i_req.iack; // [R1] [R4]
               st_nxt.total      = i_req.size;
               st_nxt.done_bytes = 2'h0;
               st_nxt.racc       = 32'h0000_0000;
               st_nxt.fault      = 1'b0;
               st_nxt.halt       = 1'b0;
               st_nxt.autovec    = 1'b0;
               st_nxt.st         = aebm_pkg::ST_SETUP;
            end
         end
         aebm_pkg::ST_SETUP: begin
            // [R8] strobe one phase after the outputs settle
            st_nxt.as_n   = 1'b0;
            st_nxt.ds_n   = !st_r.ctl.read ? 1'b1 : 1'b0; // [R12]
            st_nxt.mon    = 8'h00;
            st_nxt.st     = aebm_pkg::ST_ADDR;
         end
         aebm_pkg::ST_ADDR: begin
            if (!st_r.ctl.read) begin
               st_nxt.dout = wbus; // [R10] [R11]
               st_nxt.oe   = 1'b1;
            end
            st_nxt.st = aebm_pkg::ST_DATA;
         end
         aebm_pkg::ST_DATA: begin
            st_nxt.ds_n = 1'b0; // [R13]
            st_nxt.st   = aebm_pkg::ST_WAIT;
         end
         aebm_pkg::ST_WAIT: begin
            st_nxt.mon = st_r.mon + 8'h01;
            // [R16] [R18] fault wins over acknowledges
            if (!fault_n || st_r.mon >= MON_CYC) begin // [R17]
               st_nxt.fault = 1'b1;
               st_nxt.halt  = !halt_n;
               st_nxt.st    = aebm_pkg::ST_END;
            end else if (st_r.ctl.space == `AEBM_SPACE_CPU && !auto_vector_request_n) begin
               st_nxt.autovec = 1'b1; // [R19] [R20]
               st_nxt.st      = aebm_pkg::ST_END;
            end else if (term_ack) begin // [R14] [R22]
               if (st_r.ctl.read) begin
                  st_nxt.racc = racc_m; // [R9]
               end
               // [R21] a last single byte moves one byte even on a wide even piece
               st_nxt.done_bytes = 2'(st_r.done_bytes +
                  ((st_r.ctl.size == `AEBM_SIZE_BYTE) ? 2'h1 : moved));
               st_nxt.st         = aebm_pkg::ST_END;
            end
         end
         aebm_pkg::ST_END: begin
            st_nxt.as_n = 1'b1;
            st_nxt.ds_n = 1'b1;
            st_nxt.oe   = 1'b0;
            if (!st_r.fault && !st_r.autovec && remain != 2'h0) begin
               // [R21] next piece: address of its first byte, size = bytes left
               st_nxt.ctl.addr = `AEBM_ADDR_W'(i_req.addr + {22'h0, st_r.done_bytes});
               st_nxt.ctl.size = remain; // [R2]
               st_nxt.st       = aebm_pkg::ST_SETUP;
            end else begin
               st_nxt.rsp.done    = 1'b1;
               st_nxt.rsp.fault   = st_r.fault;
               st_nxt.rsp.autovec = st_r.autovec;
               st_nxt.rsp.rdata   = st_r.racc;
               st_nxt.st          = aebm_pkg::ST_IDLE;
            end
         end
         default: begin
            st_nxt.st = aebm_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_r          <= '0;
         st_r.st       <= aebm_pkg::ST_IDLE;
         st_r.as_n     <= 1'b1;
         st_r.ds_n     <= 1'b1;
         st_r.ctl.read <= 1'b1;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   // [R3] controls only change in idle, setup or end, never with strobe low
   assign o_ctl                 = st_r.ctl;
   assign o_addr_valid_strobe_n = st_r.as_n;
   assign o_data_valid_strobe_n = st_r.ds_n;
   assign o_data                = st_r.dout;
   assign o_data_oe             = st_r.oe;
   assign o_rsp                 = st_r.rsp;
   assign o_busy                = (st_r.st != aebm_pkg::ST_IDLE);
   assign o_halt_fault          = st_r.rsp.done & st_r.rsp.fault & st_r.halt;
endmodule : aebm_master

// [dv/aebm_master_properties.sv]
/*
 port checker for the external bus master.
 assumes i_ce held high; bound to every aebm_master instance below.
*/
`timescale 1ns/100ps
`include "aebm_consts.svh"
module aebm_master_properties (
   // clock and reset
   input  wire logic                i_clk_sys,
   input  wire logic                i_reset,
   // request side
   input  wire aebm_pkg::aebm_req_t i_req,
   input  wire aebm_pkg::aebm_rsp_t o_rsp,
   input  wire logic                o_busy,
   // bus side
   input  wire aebm_pkg::aebm_ctl_t o_ctl,
   input  wire logic                o_addr_valid_strobe_n,
   input  wire logic                o_data_valid_strobe_n,
   input  wire logic                o_data_oe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////
   sequence s_wr_start;
      $fell(o_addr_valid_strobe_n) && !o_ctl.read;
   endsequence
   sequence s_rd_start;
      $fell(o_addr_valid_strobe_n) && o_ctl.read;
   endsequence
   ////////////////////////////////////////
   a_ctl_held: assert property (
      !o_addr_valid_strobe_n && !$past(o_addr_valid_strobe_n) |-> $stable(o_ctl))
      else $error("controls moved under address strobe");
   a_first_piece: assert property (
      $rose(o_busy) |-> o_ctl.addr == i_req.addr && o_ctl.size == i_req.size)
      else $error("first piece address or size wrong");
   a_as_delay: assert property (
      $rose(o_busy) |-> o_addr_valid_strobe_n ##1 !o_addr_valid_strobe_n)
      else $error("address strobe not one phase after start");
   a_rd_dstrobe: assert property (
      s_rd_start |-> !o_data_valid_strobe_n)
      else $error("read data strobe late");
   a_wr_data: assert property (
      s_wr_start |-> !o_data_oe ##1 o_data_oe)
      else $error("write data not one phase after strobe");
   a_wr_dstrobe: assert property (
      s_wr_start |-> o_data_valid_strobe_n [*2] ##1 !o_data_valid_strobe_n)
      else $error("write data strobe not one cycle after strobe");
   a_wr_drive: assert property (
      !o_data_valid_strobe_n && !o_ctl.read |-> o_data_oe)
      else $error("write without data drive");
   a_cpu_space: assert property (
      !o_addr_valid_strobe_n && o_ctl.space == `AEBM_SPACE_CPU |-> i_req.iack)
      else $error("cpu space on an ordinary cycle");
   a_dir_change: assert property (
      $changed(o_ctl.read) |-> o_addr_valid_strobe_n
         && o_ctl.read == (i_req.read | i_req.iack))
      else $error("direction changed without reversal");
   a_cycle_bound: assert property (
      $fell(o_addr_valid_strobe_n) |-> ##[1:90] o_addr_valid_strobe_n)
      else $error("bus cycle never terminated");
   a_auto_vector_request_iack: assert property (
      o_rsp.done && o_rsp.autovec |-> i_req.iack)
      else $error("autovector outside acknowledge cycle");
endmodule : aebm_master_properties

bind aebm_master aebm_master_properties u_aebm_master_properties (
   .i_clk_sys, .i_reset, .i_req, .o_rsp, .o_busy, .o_ctl,
   .o_addr_valid_strobe_n, .o_data_valid_strobe_n, .o_data_oe);

// [dv/aebm_slave_model.sv]
/*
 behavioural external slave: 8 or 16-bit port, set latency, chosen termination.
 assumes mode 0 ack, 1 fault, 2 fault with halt, 3 autovector, 4 silent,
 5 reserved acknowledge pair.
*/
`timescale 1ns/100ps
module aebm_slave_model (
   // clock and scenario
   input  wire logic                i_clk_sys,
   input  wire logic                i_port8,
   input  wire logic [1:0]          i_lat,
   input  wire logic [2:0]          i_mode,
   // bus from master
   input  wire aebm_pkg::aebm_ctl_t i_ctl,
   input  wire logic                i_as_n,
   input  wire logic                i_ds_n,
   input  wire logic [15:0]         i_wdata,
   // terminations and data
   output logic                     o_ack_hi_n,
   output logic                     o_ack_lo_n,
   output logic                     o_fault_n,
   output logic                     o_halt_n,
   output logic                     o_auto_vector_request_n,
   output logic      [15:0]         o_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] cnt;
   logic [7:0] a;
   assign a = i_ctl.addr[7:0];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
      cnt = 8'h00;
      {o_ack_hi_n, o_ack_lo_n, o_fault_n, o_halt_n, o_auto_vector_request_n} = 5'h1F;
      o_rdata = 16'h5A5A;
   end
   ////////////////////////////////////////
   always @(posedge i_clk_sys) begin
      if (i_as_n) begin
         cnt <= 8'h00;
         {o_ack_hi_n, o_ack_lo_n, o_fault_n, o_halt_n, o_auto_vector_request_n} <= 5'h1F;
         // released bus keeps toggling so stale data never looks valid
         o_rdata <= ~o_rdata;
      end else if (!i_ds_n) begin
         cnt <= cnt + 8'h01;
         if (cnt == {6'h00, i_lat}) begin
            case (i_mode)
               3'h0: begin
                  {o_ack_hi_n, o_ack_lo_n} <= i_port8 ? 2'h2 : 2'h1;
                  if (i_ctl.read) begin
                     o_rdata <= i_port8 ? {mem[a], ~mem[a]} :
                        {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
                  end else if (i_port8) begin
                     mem[a] <= i_wdata[15:8];
                  end else if (a[0]) begin
                     mem[a] <= i_wdata[7:0];
                  end else begin
                     mem[a] <= i_wdata[15:8];
                     if (i_ctl.size != 2'h1) mem[a + 8'h01] <= i_wdata[7:0];
                  end
               end
               3'h1: o_fault_n <= 1'b0;
               3'h2: {o_fault_n, o_halt_n} <= 2'h0;
               3'h3: o_auto_vector_request_n <= 1'b0;
               3'h5: {o_ack_hi_n, o_ack_lo_n} <= 2'h0;
               default: ;
            endcase
         end
      end
   end
endmodule : aebm_slave_model

// [dv/tb_top.sv]
/*
 self-checking bench: bus master against the slave model and a byte reference.
 assumes the package, design, checker and slave model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic                i_clk_sys  = 1'b0;
   logic                i_reset    = 1'b1;
   aebm_pkg::aebm_req_t req        = '0;
   aebm_pkg::aebm_rsp_t rsp;
   aebm_pkg::aebm_ctl_t ctl;
   logic                as_n, ds_n, oe, busy, hflt;
   logic                ack_hi_n, ack_lo_n, flt_n, halt_n, auto_vector_request_n;
   logic [15:0]         wbus, rbus;
   logic                port8      = 1'b0;
   logic [1:0]          lat        = 2'h0;
   logic [2:0]          mode       = 3'h0;
   logic [15:0]         seed       = 16'h002A;
   int                  failures   = 0;
   int                  num_checks = 0;
   int                  ref_mem [256];

   always #10 i_clk_sys = ~i_clk_sys;

   aebm_master u_aebm_master (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(1'b1),
      .i_req(req), .o_rsp(rsp), .o_busy(busy), .o_halt_fault(hflt), .o_ctl(ctl),
      .o_addr_valid_strobe_n(as_n), .o_data_valid_strobe_n(ds_n), .i_data(rbus),
      .o_data(wbus), .o_data_oe(oe), .i_xfer_ack_hi_n(ack_hi_n), .i_xfer_ack_lo_n(ack_lo_n),
      .i_bus_fault_term_n(flt_n), .i_halt_n(halt_n), .i_auto_vector_request_n(auto_vector_request_n));
   aebm_slave_model u_aebm_slave_model (.i_clk_sys(i_clk_sys), .i_port8(port8),
      .i_lat(lat), .i_mode(mode), .i_ctl(ctl), .i_as_n(as_n), .i_ds_n(ds_n),
      .i_wdata(wbus), .o_ack_hi_n(ack_hi_n), .o_ack_lo_n(ack_lo_n), .o_fault_n(flt_n),
      .o_halt_n(halt_n), .o_auto_vector_request_n(auto_vector_request_n), .o_rdata(rbus));
   ////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic summarize();
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic xfer(input logic rd, input logic [23:0] a, input logic [1:0] sz,
      input logic [2:0] sp, input logic iack, input logic [31:0] wd, input logic [2:0] md);
      int n, left, k, cyc;
      logic [23:0] pa;
      logic [31:0] exp;
      logic        prev_as;
      n = (sz == 2'h0) ? 4 : int'(sz);
      left = n;
      pa = a;
      prev_as = 1'b1;
      cyc = 0;
      exp = '0;
      @(negedge i_clk_sys);
      mode = md;
      req = '{valid: 1'b1, addr: a, size: sz, space: sp, read: rd, iack: iack, wdata: wd};
      do begin
         @(negedge i_clk_sys);
         cyc++;
         if (!as_n && prev_as) begin
            `CHK("piece addr", pa, ctl.addr)
            `CHK("piece size", 2'(left), ctl.size)
            `CHK("space", iack ? 3'h7 : (sp == 3'h7 ? 3'h5 : sp), ctl.space)
            `CHK("direction", rd | iack, ctl.read)
            k = (port8 || pa[0] || left == 1) ? 1 : 2;
            left -= k;
            pa += 24'(k);
         end
         prev_as = as_n;
      end while (rsp.done !== 1'b1 && cyc < 400);
      req.valid = 1'b0;
      `CHK("done", 1'b1, rsp.done)
      // reserved pair waits like silence, so the monitor must fault it
      `CHK("fault", md != 3'h0 && !(md == 3'h3 && iack), rsp.fault)
      `CHK("halt fault", md == 3'h2, hflt)
      `CHK("autovector", md == 3'h3 && iack, rsp.autovec)
      if (md == 3'h0) begin
         `CHK("pieces left", 0, left)
         for (int i = 0; i < n; i++) begin
            if (rd) exp[31-8*i -: 8] = 8'(ref_mem[(a + i) & 255]);
            else ref_mem[(a + i) & 255] = int'(wd[31-8*i -: 8]);
         end
         if (rd) `CHK("read data", exp >> (32 - 8*n), rsp.rdata >> (32 - 8*n))
      end
   endtask : xfer
   ////////////////////////////////////////
   initial begin
      logic [23:0] ad;
      for (int i = 0; i < 256; i++) ref_mem[i] = i ^ 8'hA5;
      repeat (3) @(negedge i_clk_sys);
      i_reset = 1'b0;
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            port8 = p[0];
            lat = seed[1:0];
            ad = {16'h0000, seed[15:9], (s == 1) ? seed[8] : 1'b0};
            repeat (2) xfer(1'b0, ad, 2'(s), 3'h1, 1'b0, {seed, lfsr(seed)}, 3'h0);
            xfer(1'b1, ad, 2'(s), 3'h2, 1'b0, '0, 3'h0);
         end
      end
      for (int s = 0; s < 8; s++) xfer(1'b1, 24'h000010, 2'h2, 3'(s), 1'b0, '0, 3'h0);
      for (int m = 1; m < 6; m++) xfer(1'b1, 24'h000020, 2'h2, 3'h5, 1'b0, '0, 3'(m));
      xfer(1'b1, 24'h000000, 2'h2, 3'h7, 1'b1, '0, 3'h3);
      summarize();
   end

   // about ten times the expected run length
   initial begin
      #200000;
      failures++;
      summarize();
   end
endmodule : tb_top
